// *** owd_pkg.sv ***
// Shared constants, layouts and carrier types for the option word decoder.
package owd_pkg;

	localparam int OWD_WORD_W = 15;
	localparam int OWD_DATA_W = 32;
	localparam int OWD_ADDR_W = 5;

	// Field positions inside word 0.
	localparam int W0_SRC_BIT = 14;
	localparam int W0_PERIOD_BIT = 11;
	localparam int W0_LVR_HI = 8;
	localparam int W0_LVR_LO = 7;
	localparam int W0_RSTPIN_BIT = 6;
	localparam int W0_WDT_BIT = 5;
	localparam int W0_GWIDTH_BIT = 4;
	localparam int W0_GOFF_BIT = 3;
	localparam int W0_PROD_HI = 2;
	// Field positions inside word 1.
	localparam int W1_MODE_BIT = 14;
	localparam int W1_HALT_BIT = 12;
	localparam int W1_TRIM_HI = 11;
	localparam int W1_TRIM_LO = 7;
	localparam int W1_FREQ_HI = 6;
	localparam int W1_FREQ_LO = 5;
	localparam int W1_OSC_HI = 3;
	localparam int W1_OSC_LO = 1;
	localparam int W1_OD_BIT = 0;
	// Field positions inside word 2.
	localparam int W2_WTRIM_HI = 14;
	localparam int W2_WTRIM_LO = 11;
	localparam int W2_TAG_HI = 8;

	// Values the words hold before the load from program memory completes.
	localparam logic [14:0] W0_RST = 15'h0000;
	localparam logic [14:0] W1_RST = 15'h2010;
	localparam logic [14:0] W2_RST = 15'h0000;
	localparam logic [1:0] FREQ_REG_RST = 2'h0;

	// Register byte offsets.
	localparam logic [4:0] OFS_WORD0 = 5'h00;
	localparam logic [4:0] OFS_WORD1 = 5'h04;
	localparam logic [4:0] OFS_WORD2 = 5'h08;
	localparam logic [4:0] OFS_STATUS = 5'h0c;
	localparam logic [4:0] OFS_FREQ = 5'h10;

	// Timing counts, in oscillator periods (one clk_i period each).
	localparam int GLITCH_LONG = 32;
	localparam int GLITCH_SHORT = 8;
	localparam logic [1:0] PERIOD_FOUR = 2'h3;
	localparam logic [1:0] PERIOD_TWO = 2'h1;

	typedef enum logic [2:0] {
		OSC_STD_CRYSTAL = 3'h0,
		OSC_HIGH_CRYSTAL = 3'h1,
		OSC_LOW_CRYSTAL_A = 3'h2,
		OSC_LOW_CRYSTAL_B = 3'h3,
		OSC_IRC_PORT = 3'h4,
		OSC_IRC_CLKOUT = 3'h5,
		OSC_ERC_PORT = 3'h6,
		OSC_ERC_CLKOUT = 3'h7
	} owd_osc_t;

	typedef enum logic [1:0] {
		LVR_OFF = 2'h0,
		LVR_2V7 = 2'h1,
		LVR_3V7 = 2'h2,
		LVR_4V2 = 2'h3
	} owd_lvr_t;

	typedef enum logic [3:0] {
		FS_W0 = 4'b0001,
		FS_W1 = 4'b0010,
		FS_W2 = 4'b0100,
		FS_DONE = 4'b1000
	} owd_fetch_st_t;

	typedef struct packed {
		logic [14:0] w0;
		logic [14:0] w1;
		logic [14:0] w2;
	} owd_words_t;

	typedef struct packed {
		logic osc_freq_source_sel;
		logic instr_period_sel;
		logic lvr_enable;
		owd_lvr_t lvr_level;
		logic reset_pin_sel;
		logic watchdog_on;
		logic glitch_width_sel;
		logic glitch_filter_off_n;
		logic [2:0] product_field;
		logic initial_cpu_mode;
		logic halt_permit;
		logic [4:0] rc_osc_trim;
		logic [1:0] rc_freq_opt;
		owd_osc_t osc_mode;
		logic internal_rc_osc;
		logic external_rc_osc;
		logic rc_clock_output;
		logic clkout_opendrain_sel;
		logic [3:0] watchdog_osc_trim;
		logic [8:0] customer_tag;
	} owd_cfg_t;

	typedef struct packed {
		logic read;
		logic write;
		logic [4:0] address;
		logic [31:0] writedata;
	} owd_avs_req_t;

	typedef struct packed {
		logic [31:0] readdata;
		logic waitrequest;
	} owd_avs_rsp_t;

endpackage

// *** owd_fetch.sv ***
// Reads the three option words from program memory once after reset.
`timescale 1ns/100ps
module owd_fetch import owd_pkg::*; (
	input wire logic clk_i,
	input wire logic nrst_i,
	output logic mem_rd_o,
	output logic [1:0] mem_addr_o,
	input wire logic [14:0] mem_data_i,
	input wire logic mem_valid_i,
	output owd_words_t words_o,
	output logic done_o
);
	typedef struct packed {
		owd_fetch_st_t st;
		owd_words_t words;
	} owd_fetch_state_t;

	owd_fetch_state_t s_r;
	owd_fetch_state_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		case (s_r.st)
			FS_W0: begin
				if (mem_valid_i) begin
					s_nxt.words.w0 = mem_data_i;
					s_nxt.st = FS_W1;
				end
			end
			FS_W1: begin
				if (mem_valid_i) begin
					s_nxt.words.w1 = mem_data_i;
					s_nxt.st = FS_W2;
				end
			end
			FS_W2: begin
				if (mem_valid_i) begin
					s_nxt.words.w2 = mem_data_i;
					s_nxt.st = FS_DONE;
				end
			end
			FS_DONE: s_nxt = s_r;
			default: s_nxt.st = FS_W0;
		endcase
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_r <= '{st: FS_W0, words: '{w0: W0_RST, w1: W1_RST, w2: W2_RST}};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign mem_rd_o = (s_r.st != FS_DONE);
	assign mem_addr_o = (s_r.st == FS_W1) ? 2'h1 : ((s_r.st == FS_W2) ? 2'h2 : 2'h0);
	assign words_o = s_r.words;
	assign done_o = (s_r.st == FS_DONE);

	property p_done_sticks;
		@(posedge clk_i) disable iff (!nrst_i)
		done_o |=> done_o && $stable(words_o);
	endproperty
	a_done_sticks: assert property (p_done_sticks) else $error("loaded words changed");
endmodule

// *** owd_filter.sv ***
// Synchronises a pin and rejects pulses shorter than the selected width.
`timescale 1ns/100ps
module owd_filter import owd_pkg::*; #(
	parameter int LONG_LEN = GLITCH_LONG,
	parameter int SHORT_LEN = GLITCH_SHORT
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic pin_i,
	input wire logic width_sel_i,
	input wire logic filter_off_n_i,
	output logic level_o
);
	generate
		if (SHORT_LEN < 1 || LONG_LEN < SHORT_LEN || LONG_LEN > 63) begin : g_bad_len
			$error("owd_filter lengths out of range");
		end
	endgenerate

	typedef struct packed {
		logic s1;
		logic s2;
		logic out;
		logic [5:0] cnt;
	} owd_filt_state_t;

	owd_filt_state_t s_r;
	owd_filt_state_t s_nxt;
	logic [5:0] len;

	always_comb begin
		len = width_sel_i ? 6'(SHORT_LEN) : 6'(LONG_LEN);
		s_nxt = s_r;
		s_nxt.s1 = pin_i;
		s_nxt.s2 = s_r.s1;
		if (filter_off_n_i) begin
			s_nxt.out = s_r.s2;
			s_nxt.cnt = 6'h00;
		end else if (s_r.s2 == s_r.out) begin
			s_nxt.cnt = 6'h00;
		end else if (s_r.cnt + 6'h01 >= len) begin
			s_nxt.out = s_r.s2;
			s_nxt.cnt = 6'h00;
		end else begin
			s_nxt.cnt = s_r.cnt + 6'h01;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_r <= '{s1: 1'b1, s2: 1'b1, out: 1'b1, cnt: 6'h00};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign level_o = s_r.out;

	property p_short_pulse_blocked;
		@(posedge clk_i) disable iff (!nrst_i)
		(!filter_off_n_i && !width_sel_i && s_r.s2 != s_r.out && s_r.cnt == 6'h00)
			|=> (level_o == $past(level_o));
	endproperty
	a_short_pulse_blocked: assert property (p_short_pulse_blocked) else $error("pulse passed early");

	property p_bypass_follows;
		@(posedge clk_i) disable iff (!nrst_i)
		filter_off_n_i |=> level_o == $past(s_r.s2);
	endproperty
	a_bypass_follows: assert property (p_bypass_follows) else $error("bypass not direct");
endmodule

// *** owd_decoder.sv ***
// Option word decoder: loads the option words and drives static settings.
//
// The placing of the registers and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/100ps
module owd_decoder import owd_pkg::*; (
	input wire logic clk_i,
	input wire logic nrst_i,
	output logic mem_rd_o,
	output logic [1:0] mem_addr_o,
	input wire logic [14:0] mem_data_i,
	input wire logic mem_valid_i,
	input wire owd_avs_req_t avs_req_i,
	output owd_avs_rsp_t avs_rsp_o,
	output owd_cfg_t cfg_o,
	output logic [1:0] rc_freq_sel_o,
	output logic cpu_start_o,
	output logic instr_tick_o,
	input wire logic port8_bit3_pin_i,
	output logic port8_bit3_o,
	output logic ext_reset_n_o,
	input wire logic port5_bit4_data_i,
	input wire logic port5_bit4_oe_n_i,
	output logic osc_output_pin_o,
	output logic osc_output_pin_oe_n_o
);
	typedef struct packed {
		owd_cfg_t cfg;
		logic loaded;
		logic [1:0] freq_reg;
		logic [1:0] freq_eff;
		logic ack;
		logic [31:0] rdata;
		logic [1:0] div;
		logic tick;
		logic clk_tog;
		logic pin_o;
		logic pin_oe_n;
		logic rst_n;
		logic port_in;
	} owd_dec_state_t;

	owd_dec_state_t s_r;
	owd_dec_state_t s_nxt;
	owd_words_t words;
	logic fetch_done;
	logic pin_level;
	logic req;

	function automatic owd_cfg_t decode_words(input owd_words_t w);
		owd_cfg_t c;
		c.osc_freq_source_sel = w.w0[W0_SRC_BIT];
		c.instr_period_sel = w.w0[W0_PERIOD_BIT];
		c.lvr_level = owd_lvr_t'(w.w0[W0_LVR_HI:W0_LVR_LO]);
		c.lvr_enable = (w.w0[W0_LVR_HI:W0_LVR_LO] != 2'h0);
		c.reset_pin_sel = w.w0[W0_RSTPIN_BIT];
		c.watchdog_on = w.w0[W0_WDT_BIT];
		c.glitch_width_sel = w.w0[W0_GWIDTH_BIT];
		c.glitch_filter_off_n = w.w0[W0_GOFF_BIT];
		c.product_field = w.w0[W0_PROD_HI:0];
		c.initial_cpu_mode = w.w1[W1_MODE_BIT];
		c.halt_permit = w.w1[W1_HALT_BIT];
		c.rc_osc_trim = w.w1[W1_TRIM_HI:W1_TRIM_LO];
		c.rc_freq_opt = w.w1[W1_FREQ_HI:W1_FREQ_LO];
		c.osc_mode = owd_osc_t'(w.w1[W1_OSC_HI:W1_OSC_LO]);
		c.internal_rc_osc = (w.w1[W1_OSC_HI:W1_OSC_LO + 1] == 2'h2);
		c.external_rc_osc = (w.w1[W1_OSC_HI:W1_OSC_LO + 1] == 2'h3);
		c.rc_clock_output = w.w1[W1_OSC_HI] & w.w1[W1_OSC_LO];
		c.clkout_opendrain_sel = w.w1[W1_OD_BIT];
		c.watchdog_osc_trim = w.w2[W2_WTRIM_HI:W2_WTRIM_LO];
		c.customer_tag = w.w2[W2_TAG_HI:0];
		return c;
	endfunction

	function automatic logic [31:0] widen(input logic [14:0] w);
		return {17'h00000, w};
	endfunction

	owd_fetch u_fetch (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.mem_rd_o(mem_rd_o),
		.mem_addr_o(mem_addr_o),
		.mem_data_i(mem_data_i),
		.mem_valid_i(mem_valid_i),
		.words_o(words),
		.done_o(fetch_done)
	);

	// The filter runs bypassed on the reset settings until the load completes; the pin is
	// not trusted before then, because the CPU is still held.
	owd_filter #(
		.LONG_LEN(GLITCH_LONG),
		.SHORT_LEN(GLITCH_SHORT)
	) u_filter (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.pin_i(port8_bit3_pin_i),
		.width_sel_i(s_r.cfg.glitch_width_sel),
		.filter_off_n_i(s_r.cfg.glitch_filter_off_n),
		.level_o(pin_level)
	);

	assign req = avs_req_i.read | avs_req_i.write;

	always_comb begin
		s_nxt = s_r;
		// Settings are captured once; later reads of the words change nothing.
		if (fetch_done && !s_r.loaded) begin
			s_nxt.cfg = decode_words(words);
			s_nxt.loaded = 1'b1;
		end
		s_nxt.freq_eff = s_r.cfg.osc_freq_source_sel ? s_r.freq_reg : s_r.cfg.rc_freq_opt;

		// Instruction cycle divider, idle while the CPU is held.
		s_nxt.tick = 1'b0;
		if (s_r.loaded) begin
			if (s_r.div == 2'h0) begin
				s_nxt.div = s_r.cfg.instr_period_sel ? PERIOD_TWO : PERIOD_FOUR;
				s_nxt.tick = 1'b1;
			end else begin
				s_nxt.div = s_r.div - 2'h1;
			end
		end

		// Shared reset pin.
		if (s_r.loaded && s_r.cfg.reset_pin_sel) begin
			s_nxt.rst_n = pin_level;
			s_nxt.port_in = 1'b0;
		end else begin
			s_nxt.rst_n = 1'b1;
			s_nxt.port_in = pin_level;
		end

		// Clock-out pin. The clock image is half the block clock rate.
		s_nxt.clk_tog = ~s_r.clk_tog;
		if (!s_r.loaded || (s_r.cfg.osc_mode[2] && !s_r.cfg.rc_clock_output)) begin
			s_nxt.pin_o = port5_bit4_data_i;
			s_nxt.pin_oe_n = s_r.loaded ? port5_bit4_oe_n_i : 1'b1;
		end else if (s_r.cfg.clkout_opendrain_sel) begin
			s_nxt.pin_o = 1'b0;
			s_nxt.pin_oe_n = s_nxt.clk_tog;
		end else begin
			s_nxt.pin_o = s_nxt.clk_tog;
			s_nxt.pin_oe_n = 1'b0;
		end

		// Bus slave: one wait cycle, then the answer stands for one cycle.
		s_nxt.ack = req & ~s_r.ack;
		if (req && !s_r.ack) begin
			case (avs_req_i.address)
				OFS_WORD0: s_nxt.rdata = widen(words.w0);
				OFS_WORD1: s_nxt.rdata = widen(words.w1);
				OFS_WORD2: s_nxt.rdata = widen(words.w2);
				OFS_STATUS: s_nxt.rdata = {26'h0000000, s_r.freq_eff, s_r.cfg.osc_mode, s_r.loaded};
				OFS_FREQ: s_nxt.rdata = {30'h00000000, s_r.freq_reg};
				default: s_nxt.rdata = 32'h00000000;
			endcase
		end
		// Only the frequency register is writable; option words are not.
		if (avs_req_i.write && s_r.ack && avs_req_i.address == OFS_FREQ) begin
			s_nxt.freq_reg = avs_req_i.writedata[1:0];
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_r <= '0;
			s_r.freq_reg <= FREQ_REG_RST;
			s_r.rst_n <= 1'b1;
			s_r.pin_oe_n <= 1'b1;
			s_r.cfg.glitch_filter_off_n <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign cfg_o = s_r.cfg;
	assign rc_freq_sel_o = s_r.freq_eff;
	assign cpu_start_o = s_r.loaded;
	assign instr_tick_o = s_r.tick;
	assign ext_reset_n_o = s_r.rst_n;
	assign port8_bit3_o = s_r.port_in;
	assign osc_output_pin_o = s_r.pin_o;
	assign osc_output_pin_oe_n_o = s_r.pin_oe_n;
	assign avs_rsp_o.readdata = s_r.rdata;
	assign avs_rsp_o.waitrequest = req & ~s_r.ack;

	property p_cfg_frozen;
		@(posedge clk_i) disable iff (!nrst_i)
		s_r.loaded |=> $stable(cfg_o) && cpu_start_o;
	endproperty
	a_cfg_frozen: assert property (p_cfg_frozen) else $error("settings moved after load");

	property p_start_after_fetch;
		@(posedge clk_i) disable iff (!nrst_i)
		$rose(cpu_start_o) |-> $past(fetch_done) && cfg_o == decode_words($past(words));
	endproperty
	a_start_after_fetch: assert property (p_start_after_fetch) else $error("bad load");

	property p_four_clock_period;
		@(posedge clk_i) disable iff (!nrst_i)
		(instr_tick_o && !cfg_o.instr_period_sel) |=> !instr_tick_o [*3] ##1 instr_tick_o;
	endproperty
	a_four_clock_period: assert property (p_four_clock_period) else $error("period not 4");

	property p_two_clock_period;
		@(posedge clk_i) disable iff (!nrst_i)
		(instr_tick_o && cfg_o.instr_period_sel) |=> !instr_tick_o ##1 instr_tick_o;
	endproperty
	a_two_clock_period: assert property (p_two_clock_period) else $error("period not 2");

	property p_freq_source;
		@(posedge clk_i) disable iff (!nrst_i)
		cpu_start_o ##1 cpu_start_o |-> rc_freq_sel_o ==
			($past(cfg_o.osc_freq_source_sel) ? $past(s_r.freq_reg) : $past(cfg_o.rc_freq_opt));
	endproperty
	a_freq_source: assert property (p_freq_source) else $error("wrong frequency source");

	property p_lvr_decode;
		@(posedge clk_i) disable iff (!nrst_i)
		cpu_start_o |-> cfg_o.lvr_enable == (cfg_o.lvr_level != LVR_OFF);
	endproperty
	a_lvr_decode: assert property (p_lvr_decode) else $error("low voltage decode");

	property p_port_pin_no_reset;
		@(posedge clk_i) disable iff (!nrst_i)
		(cpu_start_o && !cfg_o.reset_pin_sel) |=> ext_reset_n_o;
	endproperty
	a_port_pin_no_reset: assert property (p_port_pin_no_reset) else $error("reset from port pin");

	property p_clkout_drive;
		@(posedge clk_i) disable iff (!nrst_i)
		(cpu_start_o && $past(cpu_start_o) && !cfg_o.clkout_opendrain_sel &&
			cfg_o.osc_mode == OSC_IRC_CLKOUT)
			|=> !osc_output_pin_oe_n_o && osc_output_pin_o != $past(osc_output_pin_o);
	endproperty
	a_clkout_drive: assert property (p_clkout_drive) else $error("clock not driven");

	property p_opendrain_never_high;
		@(posedge clk_i) disable iff (!nrst_i)
		(cpu_start_o && cfg_o.clkout_opendrain_sel && !cfg_o.osc_mode[2])
			|=> (osc_output_pin_oe_n_o || !osc_output_pin_o);
	endproperty
	a_opendrain_never_high: assert property (p_opendrain_never_high) else $error("drove high");

	property p_bus_one_wait;
		@(posedge clk_i) disable iff (!nrst_i)
		(req && !s_r.ack) |-> avs_rsp_o.waitrequest ##1 (!req || !avs_rsp_o.waitrequest);
	endproperty
	a_bus_one_wait: assert property (p_bus_one_wait) else $error("bus answer late");

	// The CPU may only start once the last word has been taken.
	property p_fetch_order;
		@(posedge clk_i) disable iff (!nrst_i)
		(mem_rd_o && mem_valid_i && mem_addr_o == 2'h2) |=>
			!mem_rd_o && !cpu_start_o ##1 cpu_start_o;
	endproperty
	a_fetch_order: assert property (p_fetch_order) else $error("start not after last word");

	property p_oe_off_before_load;
		@(posedge clk_i) disable iff (!nrst_i)
		!cpu_start_o |=> osc_output_pin_oe_n_o;
	endproperty
	a_oe_off_before_load: assert property (p_oe_off_before_load) else $error("pin driven early");

	property p_freq_write;
		@(posedge clk_i) disable iff (!nrst_i)
		(avs_req_i.write && !avs_rsp_o.waitrequest && avs_req_i.address == OFS_FREQ) |=>
			s_r.freq_reg == $past(avs_req_i.writedata[1:0]);
	endproperty
	a_freq_write: assert property (p_freq_write) else $error("frequency write lost");

	property p_watchdog_bit;
		@(posedge clk_i) disable iff (!nrst_i)
		cpu_start_o |-> cfg_o.watchdog_on == words.w0[W0_WDT_BIT];
	endproperty
	a_watchdog_bit: assert property (p_watchdog_bit) else $error("watchdog enable wrong");

	property p_product_pass;
		@(posedge clk_i) disable iff (!nrst_i)
		cpu_start_o |-> cfg_o.product_field == words.w0[W0_PROD_HI:0];
	endproperty
	a_product_pass: assert property (p_product_pass) else $error("product field wrong");

	property p_green_start;
		@(posedge clk_i) disable iff (!nrst_i)
		cpu_start_o |-> cfg_o.initial_cpu_mode == words.w1[W1_MODE_BIT];
	endproperty
	a_green_start: assert property (p_green_start) else $error("initial mode wrong");

	property p_halt_permit;
		@(posedge clk_i) disable iff (!nrst_i)
		cpu_start_o |-> cfg_o.halt_permit == words.w1[W1_HALT_BIT];
	endproperty
	a_halt_permit: assert property (p_halt_permit) else $error("halt permit wrong");

	property p_rc_trim;
		@(posedge clk_i) disable iff (!nrst_i)
		cpu_start_o |-> cfg_o.rc_osc_trim == words.w1[W1_TRIM_HI:W1_TRIM_LO];
	endproperty
	a_rc_trim: assert property (p_rc_trim) else $error("oscillator trim wrong");

	property p_crystal_decode;
		@(posedge clk_i) disable iff (!nrst_i)
		(cpu_start_o && !words.w1[W1_OSC_HI]) |->
			!cfg_o.internal_rc_osc && !cfg_o.external_rc_osc && !cfg_o.rc_clock_output;
	endproperty
	a_crystal_decode: assert property (p_crystal_decode) else $error("crystal mode decode");

	// Even RC codes hand the clock-out pin back to the port logic.
	property p_even_rc_port;
		@(posedge clk_i) disable iff (!nrst_i)
		(cpu_start_o && cfg_o.osc_mode[2] && !cfg_o.osc_mode[0]) |=>
			osc_output_pin_o == $past(port5_bit4_data_i) &&
			osc_output_pin_oe_n_o == $past(port5_bit4_oe_n_i);
	endproperty
	a_even_rc_port: assert property (p_even_rc_port) else $error("port drive lost");

	property p_wdt_trim;
		@(posedge clk_i) disable iff (!nrst_i)
		cpu_start_o |-> cfg_o.watchdog_osc_trim == words.w2[W2_WTRIM_HI:W2_WTRIM_LO];
	endproperty
	a_wdt_trim: assert property (p_wdt_trim) else $error("watchdog trim wrong");

	property p_customer_tag;
		@(posedge clk_i) disable iff (!nrst_i)
		cpu_start_o |-> cfg_o.customer_tag == words.w2[W2_TAG_HI:0];
	endproperty
	a_customer_tag: assert property (p_customer_tag) else $error("customer tag wrong");

	property p_reset_from_pin;
		@(posedge clk_i) disable iff (!nrst_i)
		(cpu_start_o && cfg_o.reset_pin_sel) |=>
			ext_reset_n_o == $past(pin_level) && !port8_bit3_o;
	endproperty
	a_reset_from_pin: assert property (p_reset_from_pin) else $error("reset pin not followed");

	property p_port_from_pin;
		@(posedge clk_i) disable iff (!nrst_i)
		(cpu_start_o && !cfg_o.reset_pin_sel) |=> port8_bit3_o == $past(pin_level);
	endproperty
	a_port_from_pin: assert property (p_port_from_pin) else $error("port pin not followed");
endmodule

// *** owd_store.sv ***
// Behavioural option storage that hands the three words to the loader.
`timescale 1ns/100ps
module owd_store import owd_pkg::*; (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic mem_rd_i,
	input wire logic [1:0] mem_addr_i,
	input wire owd_words_t words_i,
	input wire logic [3:0] lag_i,
	output logic [14:0] mem_data_o,
	output logic mem_valid_o
);
	logic [3:0] cnt_r;

	// Data toggles while not valid so that a loader taking it early is caught.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_r <= 4'h0;
			mem_valid_o <= 1'b0;
			mem_data_o <= 15'h5555;
		end else if (mem_valid_o || !mem_rd_i) begin
			cnt_r <= 4'h0;
			mem_valid_o <= 1'b0;
			mem_data_o <= ~mem_data_o;
		end else if (cnt_r >= lag_i) begin
			mem_valid_o <= 1'b1;
			case (mem_addr_i)
				2'h0: mem_data_o <= words_i.w0 & 15'h4fff;
				2'h1: mem_data_o <= words_i.w1 | 15'h2010;
				default: mem_data_o <= words_i.w2 | 15'h0600;
			endcase
		end else begin
			cnt_r <= cnt_r + 4'h1;
			mem_data_o <= ~mem_data_o;
		end
	end
endmodule

// *** owd_decoder_test.sv ***
// Self-checking bench for the option word decoder with a storage model.
`timescale 1ns/100ps
module owd_decoder_test import owd_pkg::*; ;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic mem_rd, mem_valid, cpu_start, tick, p83, ext_rst_n, osc_pin, osc_oe_n;
	logic [1:0] mem_addr, rc_sel;
	logic [14:0] mem_data;
	owd_avs_req_t avs_req = '0;
	owd_avs_rsp_t avs_rsp;
	owd_cfg_t cfg;
	owd_words_t words = '0;
	logic [3:0] lag = 4'h0;
	logic p83_pin = 1'b1;
	logic p54_d = 1'b0;
	logic p54_oe_n = 1'b1;
	int n_errors = 0;
	int tests_run = 0;

	always #50 clk_i = ~clk_i;

	owd_decoder uut (.clk_i(clk_i), .nrst_i(nrst_i), .mem_rd_o(mem_rd), .mem_addr_o(mem_addr),
		.mem_data_i(mem_data), .mem_valid_i(mem_valid), .avs_req_i(avs_req),
		.avs_rsp_o(avs_rsp), .cfg_o(cfg), .rc_freq_sel_o(rc_sel), .cpu_start_o(cpu_start),
		.instr_tick_o(tick), .port8_bit3_pin_i(p83_pin), .port8_bit3_o(p83),
		.ext_reset_n_o(ext_rst_n), .port5_bit4_data_i(p54_d), .port5_bit4_oe_n_i(p54_oe_n),
		.osc_output_pin_o(osc_pin), .osc_output_pin_oe_n_o(osc_oe_n));

	owd_store store (.clk_i(clk_i), .nrst_i(nrst_i), .mem_rd_i(mem_rd), .mem_addr_i(mem_addr),
		.words_i(words), .lag_i(lag), .mem_data_o(mem_data), .mem_valid_o(mem_valid));

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Holds the request until waitrequest is seen low at a rising edge.
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int k;
		k = 0;
		@(posedge clk_i);
		avs_req <= '{read: !wr, write: wr, address: a, writedata: d};
		do begin
			@(posedge clk_i);
			k++;
		end while (avs_rsp.waitrequest !== 1'b0 && k < 50);
		q = avs_rsp.readdata;
		if (k >= 50) n_errors++;
		avs_req <= '0;
	endtask

	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		check(q, e);
	endtask

	task automatic wait_hi(ref logic s);
		int k;
		k = 0;
		while (s !== 1'b1 && k < 200) begin
			@(negedge clk_i);
			k++;
		end
	endtask

	function automatic logic [1:0] exp_sel(input owd_words_t w, input logic [1:0] fr);
		return w.w0[14] ? fr : w.w1[6:5];
	endfunction

	// Reset pin use routes the filtered level either to reset or to the port.
	function automatic logic [1:0] pins(input logic rsel, input logic v);
		return rsel ? {v, 1'b0} : {1'b1, v};
	endfunction

	initial begin
		repeat (20000) @(posedge clk_i);
		n_errors++;
		wrap_up();
	end

	initial begin
		owd_words_t w;
		logic [2:0] c;
		logic [1:0] fr, a, b;
		logic [31:0] q;
		int k;
		k = $urandom(90615);
		for (int i = 0; i < 16; i++) begin
			c = 3'(i);
			w.w0 = 15'($urandom) & 15'h49ff;
			w.w1 = (15'($urandom) & 15'h5ff1) | 15'h2010 | {11'h0, c, 1'b0};
			w.w2 = 15'($urandom) | 15'h0600;
			@(posedge clk_i);
			nrst_i <= 1'b0;
			words <= w;
			lag <= 4'(3 * (i % 3));
			p54_d <= 1'($urandom);
			p54_oe_n <= 1'($urandom);
			repeat (8) @(posedge clk_i);
			check(cpu_start, 1'b0);
			nrst_i <= 1'b1;
			wait_hi(cpu_start);
			check(cpu_start, 1'b1);
			check(mem_rd, 1'b0);
			@(posedge clk_i);
			words <= ~w;
			repeat (2) @(negedge clk_i);
			check(cfg.osc_freq_source_sel, w.w0[14]);
			check(cfg.instr_period_sel, w.w0[11]);
			check({cfg.lvr_enable, cfg.lvr_level}, {|w.w0[8:7], w.w0[8:7]});
			check({cfg.reset_pin_sel, cfg.watchdog_on}, w.w0[6:5]);
			check({cfg.glitch_width_sel, cfg.glitch_filter_off_n}, w.w0[4:3]);
			check(cfg.product_field, w.w0[2:0]);
			check({cfg.initial_cpu_mode, cfg.halt_permit}, {w.w1[14], w.w1[12]});
			check(cfg.rc_osc_trim, w.w1[11:7]);
			check(cfg.rc_freq_opt, w.w1[6:5]);
			check(cfg.osc_mode, c);
			check({cfg.internal_rc_osc, cfg.external_rc_osc, cfg.rc_clock_output},
				{c == 3'h4 || c == 3'h5, c >= 3'h6, c[2] & c[0]});
			check(cfg.clkout_opendrain_sel, w.w1[0]);
			check(cfg.watchdog_osc_trim, w.w2[14:11]);
			check(cfg.customer_tag, w.w2[8:0]);
			rd(OFS_WORD0, {17'h0, w.w0});
			bus(1'b1, OFS_WORD0, 32'hffffffff, q);
			rd(OFS_WORD0, {17'h0, w.w0});
			rd(OFS_WORD1, {17'h0, w.w1});
			rd(OFS_WORD2, {17'h0, w.w2});
			rd(OFS_FREQ, 32'h0);
			fr = 2'($urandom);
			bus(1'b1, OFS_FREQ, {30'h0, fr}, q);
			rd(OFS_FREQ, {30'h0, fr});
			repeat (3) @(negedge clk_i);
			check(rc_sel, exp_sel(w, fr));
			rd(OFS_STATUS, {26'h0, exp_sel(w, fr), c, 1'b1});
			rd(5'h14, 32'h0);
			wait_hi(tick);
			@(negedge clk_i);
			k = 1;
			while (tick !== 1'b1 && k < 20) begin
				@(negedge clk_i);
				k++;
			end
			check(k, w.w0[11] ? 2 : 4);
			@(posedge clk_i);
			p83_pin <= 1'b0;
			repeat (6) @(negedge clk_i);
			check({ext_rst_n, p83}, pins(w.w0[6], !w.w0[3]));
			repeat (10) @(negedge clk_i);
			check({ext_rst_n, p83}, pins(w.w0[6], !w.w0[3] && !w.w0[4]));
			repeat (30) @(negedge clk_i);
			check({ext_rst_n, p83}, pins(w.w0[6], 1'b0));
			@(posedge clk_i);
			p83_pin <= 1'b1;
			@(negedge clk_i);
			a = {osc_pin, osc_oe_n};
			@(negedge clk_i);
			b = {osc_pin, osc_oe_n};
			if (c == 3'h4 || c == 3'h6) check(b, {p54_d, p54_oe_n});
			else if (w.w1[0]) check({b[1], a[0] ^ b[0]}, 2'b01);
			else check({a[1] ^ b[1], b[0]}, 2'b10);
			check(cfg.customer_tag, w.w2[8:0]);
		end
		wrap_up();
	end
endmodule
